// File: logic/stpi_top.sv
// Purpose: Process image framer for a fail-safe four-channel input module
// Assumes: Output telegram arrives as a whole with a one-cycle strobe
// Notes: Checksum and serial values are supplied, not computed, here
//
// How it works
// - Five telegram bytes each way, bytes 0-4
// - Byte meaning follows selected protocol version
// - V1: serial in byte 2, checksum bytes 3-4
// - V2: three checksum bytes, high in byte 2
// - Channels one to four in bits 0-3
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
module stpi_top
  import stpi_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Field input pins
  input wire logic input_channel_one_state_i,
  input wire logic input_channel_two_state_i,
  input wire logic input_channel_three_state_i,
  input wire logic input_channel_four_state_i,
  // Input telegram towards the controller
  output logic [TEL_W-1:0] in_image_o,
  // Output telegram from the controller
  input wire logic out_image_valid_i,
  input wire logic [TEL_W-1:0] out_image_i,
  // Decoded output telegram and selected protocol version
  output logic failure_ack_o,
  output logic failure_ack_pulse_o,
  output logic protocol_v2_o
);

  ////////////////////////////////////////////////////////////////////////
  // Channel pin synchronisation

  logic [CHAN_N-1:0] chan_raw;
  logic [CHAN_N-1:0] chan_sync;

  assign chan_raw = {input_channel_four_state_i, input_channel_three_state_i,
                     input_channel_two_state_i, input_channel_one_state_i};

  stpi_sync #(
    .WIDTH(CHAN_N)
  ) u_chan_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(chan_raw),
    .sync_o(chan_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic req;
  logic wr_acc;
  logic rd_acc;
  logic ack_q;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_acc = req & wb_we_i;
  assign rd_acc = req & ~wb_we_i;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Software-written registers

  stpi_ver_t ver_q;
  logic [7:0] status_q;
  logic [7:0] in_ser_q;
  logic [23:0] in_ck_q;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_status;
  logic [31:0] wr_ser;
  logic [31:0] wr_ck;

  assign wr_ctrl = merge({31'h0000_0000, ver_q == STPI_V2}, wb_dat_i, wb_sel_i);
  assign wr_status = merge({24'h00_0000, status_q}, wb_dat_i, wb_sel_i);
  assign wr_ser = merge({24'h00_0000, in_ser_q}, wb_dat_i, wb_sel_i);
  assign wr_ck = merge({8'h00, in_ck_q}, wb_dat_i, wb_sel_i);

  // Version select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ver_q <= STPI_V1;
    end else if (wr_acc && wb_adr_i == REG_CTRL) begin
      ver_q <= wr_ctrl[0] ? STPI_V2 : STPI_V1;
    end
  end

  // Status byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= RST_BYTE;
    end else if (wr_acc && wb_adr_i == REG_STATUS) begin
      status_q <= wr_status[7:0];
    end
  end

  // Serial number for the input telegram
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_ser_q <= RST_BYTE;
    end else if (wr_acc && wb_adr_i == REG_IN_SER) begin
      in_ser_q <= wr_ser[7:0];
    end
  end

  // Checksum for the input telegram
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_ck_q <= RST_CK;
    end else if (wr_acc && wb_adr_i == REG_IN_CK) begin
      in_ck_q <= wr_ck[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input telegram assembly

  logic [7:0] in_byte_d [TEL_BYTES];
  logic [TEL_W-1:0] in_image_d;
  logic [TEL_W-1:0] in_image_q;
  logic [7:0] in_ck_b2;
  logic [7:0] in_ck_b1;
  logic [7:0] in_ck_b0;

  // Checksum bytes, most significant first
  assign in_ck_b2 = in_ck_q[23:16];
  assign in_ck_b1 = in_ck_q[15:8];
  assign in_ck_b0 = in_ck_q[7:0];

  always_comb begin
    in_byte_d[BYTE_DATA] = {CHAN_RESERVED, chan_sync};
    in_byte_d[BYTE_CTRL] = status_q;
    if (ver_q == STPI_V1) begin
      in_byte_d[BYTE_SER] = in_ser_q;
      in_byte_d[BYTE_CK_HI] = in_ck_b1;
      in_byte_d[BYTE_CK_LO] = in_ck_b0;
    end else begin
      in_byte_d[BYTE_SER] = in_ck_b2;
      in_byte_d[BYTE_CK_HI] = in_ck_b1;
      in_byte_d[BYTE_CK_LO] = in_ck_b0;
    end
    for (int b = 0; b < TEL_BYTES; b++) begin
      in_image_d[8*b +: 8] = in_byte_d[b];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_image_q <= '0;
    end else begin
      in_image_q <= in_image_d;
    end
  end

  assign in_image_o = in_image_q;

  ////////////////////////////////////////////////////////////////////////
  // Output telegram capture

  logic [7:0] out_byte [TEL_BYTES];
  logic [7:0] out_ctrl_q;
  logic [7:0] out_ser_q;
  logic [23:0] out_ck_q;
  logic ack_pulse_q;

  always_comb begin
    for (int b = 0; b < TEL_BYTES; b++) begin
      out_byte[b] = out_image_i[8*b +: 8];
    end
  end

  // Control byte and acknowledge edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ctrl_q <= RST_BYTE;
      ack_pulse_q <= 1'b0;
    end else begin
      ack_pulse_q <= 1'b0;
      if (out_image_valid_i) begin
        out_ctrl_q <= out_byte[BYTE_CTRL];
        ack_pulse_q <= out_byte[BYTE_CTRL][ACK_BIT] & ~out_ctrl_q[ACK_BIT];
      end
    end
  end

  // Serial number and checksum by version
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ser_q <= RST_BYTE;
      out_ck_q <= RST_CK;
    end else if (out_image_valid_i) begin
      if (ver_q == STPI_V1) begin
        out_ser_q <= out_byte[BYTE_SER];
        out_ck_q <= {BYTE_ZERO, out_byte[BYTE_CK_HI], out_byte[BYTE_CK_LO]};
      end else begin
        out_ser_q <= RST_BYTE;
        out_ck_q <= {out_byte[BYTE_SER], out_byte[BYTE_CK_HI], out_byte[BYTE_CK_LO]};
      end
    end
  end

  assign failure_ack_o = out_ctrl_q[ACK_BIT];
  assign failure_ack_pulse_o = ack_pulse_q;
  assign protocol_v2_o = (ver_q == STPI_V2);

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags, write one to clear, set wins

  logic [FLG_N-1:0] flag_set;
  logic [FLG_N-1:0] flag_clr;
  logic [FLG_N-1:0] flags_q;

  always_comb begin
    flag_set = '0;
    if (out_image_valid_i) begin
      flag_set[FLG_CTRL_RSVD] = |(out_byte[BYTE_CTRL] & OUT_RSVD_MASK);
      flag_set[FLG_BYTE0] = |out_byte[BYTE_DATA];
      flag_set[FLG_FRAME] = 1'b1;
    end
  end

  // Software clear, byte lane 0 only
  always_comb begin
    flag_clr = '0;
    if (wr_acc && wb_adr_i == REG_FLAGS && wb_sel_i[0]) begin
      flag_clr = wb_dat_i[FLG_N-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux and acknowledge

  logic [31:0] rd_d;
  logic [31:0] rd_q;

  always_comb begin
    unique case (wb_adr_i)
      REG_CTRL: rd_d = {31'h0000_0000, ver_q == STPI_V2};
      REG_STATUS: rd_d = {24'h00_0000, status_q};
      REG_IN_SER: rd_d = {24'h00_0000, in_ser_q};
      REG_IN_CK: rd_d = {8'h00, in_ck_q};
      REG_CHAN: rd_d = {28'h000_0000, chan_sync};
      REG_OUT_CTRL: rd_d = {24'h00_0000, out_ctrl_q};
      REG_OUT_SER: rd_d = {24'h00_0000, out_ser_q};
      REG_OUT_CK: rd_d = {8'h00, out_ck_q};
      REG_FLAGS: rd_d = {29'h0000_0000, flags_q};
      REG_IMG_LO: rd_d = in_image_q[31:0];
      REG_IMG_HI: rd_d = {24'h00_0000, in_image_q[TEL_W-1:32]};
      default: rd_d = RD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= RD_ZERO;
    end else if (rd_acc) begin
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

endmodule

// File: logic/stpi_pkg.sv
// Purpose: Constants for the safety telegram process image block
// Assumes: 32-bit classic Wishbone, word-aligned registers
// Notes: Byte 0 of each telegram sits in bits 7:0 of the image vectors
package stpi_pkg;

  // Telegram geometry
  localparam int unsigned TEL_BYTES = 5;
  localparam int unsigned TEL_W = 40;
  localparam int unsigned CHAN_N = 4;

  // Byte positions within a telegram
  localparam int unsigned BYTE_DATA = 0;
  localparam int unsigned BYTE_CTRL = 1;
  localparam int unsigned BYTE_SER = 2;
  localparam int unsigned BYTE_CK_HI = 3;
  localparam int unsigned BYTE_CK_LO = 4;

  // Bit fields
  localparam int unsigned ACK_BIT = 7;
  localparam logic [7:0] OUT_RSVD_MASK = 8'h7F;
  localparam logic [3:0] CHAN_RESERVED = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Protocol version
  typedef enum logic {
    STPI_V1,
    STPI_V2
  } stpi_ver_t;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IN_SER = 8'h08;
  localparam logic [7:0] REG_IN_CK = 8'h0C;
  localparam logic [7:0] REG_CHAN = 8'h10;
  localparam logic [7:0] REG_OUT_CTRL = 8'h14;
  localparam logic [7:0] REG_OUT_SER = 8'h18;
  localparam logic [7:0] REG_OUT_CK = 8'h1C;
  localparam logic [7:0] REG_FLAGS = 8'h20;
  localparam logic [7:0] REG_IMG_LO = 8'h24;
  localparam logic [7:0] REG_IMG_HI = 8'h28;

  // Flag bit positions
  localparam int unsigned FLG_CTRL_RSVD = 0;
  localparam int unsigned FLG_BYTE0 = 1;
  localparam int unsigned FLG_FRAME = 2;
  localparam int unsigned FLG_N = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_CK = 24'h00_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

// File: logic/stpi_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module stpi_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// File: tb/stpi_props.sv
// Purpose: Port checker for the process image framer
// Assumes: One clock, synchronous reset
// Notes: Bound to the top module
`timescale 1ns/10ps
module stpi_props
  import stpi_pkg::*;
(
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Pins and telegrams
  input wire logic input_channel_one_state_i,
  input wire logic input_channel_two_state_i,
  input wire logic input_channel_three_state_i,
  input wire logic input_channel_four_state_i,
  input wire logic [TEL_W-1:0] in_image_o,
  input wire logic out_image_valid_i,
  input wire logic [TEL_W-1:0] out_image_i,
  input wire logic failure_ack_o,
  input wire logic failure_ack_pulse_o,
  input wire logic protocol_v2_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] up_q;
  wire logic [3:0] pins = {input_channel_four_state_i, input_channel_three_state_i,
    input_channel_two_state_i, input_channel_one_state_i};
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  ack_answer_a: assert property (take |=> wb_ack_o) else $error("bus ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("bus ack too long");
  ver_select_a: assert property (
    take && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]
    |=> protocol_v2_o == $past(wb_dat_i[0])) else $error("version not taken");
  chan_map_a: assert property (
    (up_q == 3'h7 && $stable(pins)) [*4] |-> in_image_o[3:0] == pins)
    else $error("channel bits wrong");
  rsvd_zero_a: assert property (in_image_o[7:4] == 4'h0) else $error("reserved set");
  fack_cap_a: assert property (
    out_image_valid_i |=> failure_ack_o == $past(out_image_i[15])) else $error("ack bit lost");
  pulse_rise_a: assert property (
    out_image_valid_i && out_image_i[15] && !failure_ack_o |=> failure_ack_pulse_o)
    else $error("ack pulse missing");
  pulse_cause_a: assert property (
    failure_ack_pulse_o |-> failure_ack_o && !$past(failure_ack_o)) else $error("stray pulse");
  cover property (failure_ack_pulse_o);
  cover property (protocol_v2_o && out_image_valid_i);
  cover property (take && !wb_we_i);
endmodule

bind stpi_top stpi_props stpi_props_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .input_channel_one_state_i(input_channel_one_state_i),
  .input_channel_two_state_i(input_channel_two_state_i),
  .input_channel_three_state_i(input_channel_three_state_i),
  .input_channel_four_state_i(input_channel_four_state_i), .in_image_o(in_image_o),
  .out_image_valid_i(out_image_valid_i), .out_image_i(out_image_i),
  .failure_ack_o(failure_ack_o), .failure_ack_pulse_o(failure_ack_pulse_o),
  .protocol_v2_o(protocol_v2_o));

// File: tb/stpi_ctrl_model.sv
// Purpose: Safety controller sending output telegrams
// Assumes: Same clock as the block
// Notes: Stale telegram is inverted every cycle
`timescale 1ns/10ps
module stpi_ctrl_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the bench
  input wire logic send_i,
  input wire logic ack_i,
  input wire logic [23:0] pay_i,
  // Telegram towards the block
  output logic valid_o,
  output logic [39:0] image_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      image_o <= 40'h00_0000_0000;
    end else if (send_i) begin
      valid_o <= 1'b1;
      image_o <= {pay_i[7:0], pay_i[15:8], pay_i[23:16], ack_i, 7'h00, 8'h00};
    end else begin
      valid_o <= 1'b0;
      image_o <= ~image_o;
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the process image framer
// Assumes: Classic single-cycle bus master
// Notes: One task per scenario
`timescale 1ns/10ps
module testbench
  import stpi_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, ch;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic out_image_valid_i, failure_ack_o, failure_ack_pulse_o, protocol_v2_o, send, ack;
  logic [TEL_W-1:0] in_image_o, out_image_i;
  logic [23:0] pay;
  int fail_count, check_count, cyc_n;
  stpi_top stpi_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .input_channel_one_state_i(ch[0]), .input_channel_two_state_i(ch[1]),
    .input_channel_three_state_i(ch[2]), .input_channel_four_state_i(ch[3]),
    .in_image_o(in_image_o), .out_image_valid_i(out_image_valid_i),
    .out_image_i(out_image_i), .failure_ack_o(failure_ack_o),
    .failure_ack_pulse_o(failure_ack_pulse_o), .protocol_v2_o(protocol_v2_o));
  stpi_ctrl_model stpi_ctrl_model_inst (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
    .ack_i(ack), .pay_i(pay), .valid_o(out_image_valid_i), .image_o(out_image_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic tel(input logic a, input logic [23:0] p);
    send <= 1'b1;
    ack <= a;
    pay <= p;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_reset;
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 40'h0, rd);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 40'h0, rd);
    $display("test reset done");
  endtask
  task automatic t_in(input logic v, input logic [3:0] c);
    ch <= c;
    bus(1'b1, REG_CTRL, {31'h0, v});
    bus(1'b1, REG_STATUS, 32'h0000_00A5);
    bus(1'b1, REG_IN_SER, 32'h0000_003C);
    bus(1'b1, REG_IN_CK, 32'h0012_3456);
    repeat (4) @(posedge clk_i);
    chk("in_image", {16'h5634, v ? 8'h12 : 8'h3C, 8'hA5, 4'h0, c}, in_image_o);
    chk("version", v, protocol_v2_o);
    bus(1'b0, REG_IMG_HI, 32'h0);
    chk("img_hi", 40'h56, rd);
    bus(1'b0, REG_IMG_LO, 32'h0);
    chk("img_lo", {8'h34, v ? 8'h12 : 8'h3C, 8'hA5, 4'h0, c}, rd);
    bus(1'b0, REG_CHAN, 32'h0);
    chk("chan", {4'h0, c}, rd);
    $display("test input image done");
  endtask
  task automatic t_out(input logic v);
    tel(1'b1, 24'hC3_5A96);
    chk("pulse", 1'b1, failure_ack_pulse_o);
    bus(1'b0, REG_FLAGS, 32'h0);
    chk("flags", 40'h4, rd);
    bus(1'b1, REG_FLAGS, 32'h0000_0007);
    bus(1'b0, REG_FLAGS, 32'h0);
    chk("flags_clr", 40'h0, rd);
    bus(1'b0, REG_OUT_CK, 32'h0);
    chk("out_ck", v ? 40'hC3_5A96 : 40'h5A96, rd);
    bus(1'b0, REG_OUT_SER, 32'h0);
    chk("out_ser", v ? 40'h0 : 40'hC3, rd);
    tel(1'b1, 24'h00_0000);
    chk("no_pulse", 1'b0, failure_ack_pulse_o);
    tel(1'b0, 24'h00_0000);
    chk("ack_clear", 1'b0, failure_ack_o);
    $display("test output image done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    {ch, send, ack, pay} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_in(1'b0, 4'h9);
    t_out(1'b0);
    t_in(1'b1, 4'h6);
    t_out(1'b1);
    complete_run;
  end
endmodule
